/* File: hw/ppsm_pkg.sv */
// constants for the peripheral pin select matrix
// Functional notes
// - each remappable pin's own field picks the peripheral output driving it
// - output map registers hold 6-bit fields, one field per pin
// - code zero disconnects peripherals; pin keeps its port function
// - codes 1,2 route serial1 tx/rts; codes 3,4 route serial2 tx/rts
// - codes 5,6,7 route spi1 data, clock, select; code 10 spi2 select
// - codes 11,12,13 route codec data, clock, frame sync outputs
// - code 14 routes can1 transmit, code 15 can2 transmit
// - codes 16 to 23 route compare channels 1 to 8 in order
// - codes 24,25,26 route comparators 1,2,3
// - code 27 routes serial3 transmit, code 28 serial3 rts
// - each peripheral input owns a 7-bit field naming its source pin
// - input field all ones selects pin 127; 0 is ground, 1 comparator 1, other values their own pin
// - unused input register bits ignore writes and read zero
package ppsm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int OSEL_W = 6;
  localparam int ISEL_W = 7;
  localparam int NUM_IN_PINS = 128;
  // register indices
  localparam logic [7:0] ADDR_IN_TIMER = 8'h00;
  localparam logic [7:0] ADDR_IN_FSYNC = 8'h01;
  localparam logic [7:0] ADDR_IN_CAPT = 8'h02;
  localparam logic [7:0] ADDR_OUT_BASE = 8'h10;
  // field positions
  localparam int FLD_LO = 0;
  localparam int FLD_HI = 8;
  // reset values
  localparam logic [5:0] OSEL_RESET = 6'h00;
  localparam logic [6:0] ISEL_RESET = 7'h00;
  // input select specials
  localparam logic [6:0] ISEL_VSS = 7'h00;
  localparam logic [6:0] ISEL_COMPARATOR1_RESULT = 7'h01;
  // output codes
  localparam logic [5:0] OC_NULL = 6'h00;
  localparam logic [5:0] OC_S1_TX = 6'h01;
  localparam logic [5:0] OC_S1_RTS = 6'h02;
  localparam logic [5:0] OC_S2_TX = 6'h03;
  localparam logic [5:0] OC_S2_RTS = 6'h04;
  localparam logic [5:0] OC_SPI1_DO = 6'h05;
  localparam logic [5:0] OC_SPI1_CK = 6'h06;
  localparam logic [5:0] OC_SPI1_SS = 6'h07;
  localparam logic [5:0] OC_SPI2_SS = 6'h0A;
  localparam logic [5:0] OC_COD_DO = 6'h0B;
  localparam logic [5:0] OC_COD_CK = 6'h0C;
  localparam logic [5:0] OC_COD_FS = 6'h0D;
  localparam logic [5:0] OC_CAN1_TX = 6'h0E;
  localparam logic [5:0] OC_CAN2_TX = 6'h0F;
  localparam logic [5:0] OC_CMPCH_BASE = 6'h10;
  localparam logic [5:0] OC_CMPTR_BASE = 6'h18;
  localparam logic [5:0] OC_S3_TX = 6'h1B;
  localparam logic [5:0] OC_S3_RTS = 6'h1C;
  localparam int NUM_CMPCH = 8;
  localparam int NUM_CMPTR = 3;
endpackage

/* File: hw/ppsm_mux.sv */
// peripheral pin select matrix: register file, output and input routing
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module ppsm_mux
  import ppsm_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic serial1_transmit,
  input wire logic serial1_request_to_send,
  input wire logic serial2_transmit,
  input wire logic serial2_request_to_send,
  input wire logic serial3_transmit,
  input wire logic serial3_request_to_send,
  input wire logic spi1_data_out,
  input wire logic spi1_clock_out,
  input wire logic spi1_slave_select,
  input wire logic spi2_slave_select,
  input wire logic codec_serial_data_out,
  input wire logic codec_serial_clock,
  input wire logic codec_frame_sync,
  input wire logic can1_transmit,
  input wire logic can2_transmit,
  input wire logic [NUM_CMPCH-1:0] compare_channel_output,
  input wire logic [NUM_CMPTR-1:0] comparator_output,
  input wire logic [NUM_PINS-1:0] port_data,
  output logic [NUM_PINS-1:0] remappable_pin,
  output logic [NUM_PINS-1:0] pin_remapped,
  input wire logic [NUM_IN_PINS-1:0] remappable_pin_in,
  output logic timer2_clock_in,
  output logic timer3_clock_in,
  output logic frame_sync_in,
  output logic capture11_in,
  output logic capture12_in
);

  localparam int NUM_OREGS = NUM_PINS / 2;

  if (NUM_PINS < 2 || NUM_PINS % 2 != 0 || NUM_PINS > 64) begin : g_chk
    $error("NUM_PINS must be even, between 2 and 64");
  end

  typedef struct packed {
    logic [NUM_PINS-1:0][OSEL_W-1:0] osel;
    logic [ISEL_W-1:0] sel_t2;
    logic [ISEL_W-1:0] sel_t3;
    logic [ISEL_W-1:0] sel_fs;
    logic [ISEL_W-1:0] sel_ic11;
    logic [ISEL_W-1:0] sel_ic12;
    logic [DATA_W-1:0] rdata;
    logic [NUM_PINS-1:0] pin;
    logic [NUM_PINS-1:0] remapped;
    logic t2;
    logic t3;
    logic fs;
    logic ic11;
    logic ic12;
  } ppsm_state_t;

  ppsm_state_t st;
  ppsm_state_t next_st;
  logic [(1<<OSEL_W)-1:0] avail;

  // one line per code; codes nobody claims stay low
  always_comb begin
    avail = '0;
    avail[OC_S1_TX] = serial1_transmit;
    avail[OC_S1_RTS] = serial1_request_to_send;
    avail[OC_S2_TX] = serial2_transmit;
    avail[OC_S2_RTS] = serial2_request_to_send;
    avail[OC_SPI1_DO] = spi1_data_out;
    avail[OC_SPI1_CK] = spi1_clock_out;
    avail[OC_SPI1_SS] = spi1_slave_select;
    avail[OC_SPI2_SS] = spi2_slave_select;
    avail[OC_COD_DO] = codec_serial_data_out;
    avail[OC_COD_CK] = codec_serial_clock;
    avail[OC_COD_FS] = codec_frame_sync;
    avail[OC_CAN1_TX] = can1_transmit;
    avail[OC_CAN2_TX] = can2_transmit;
    for (int j = 0; j < NUM_CMPCH; j++) begin
      avail[OC_CMPCH_BASE + 6'(j)] = compare_channel_output[j];
    end
    for (int j = 0; j < NUM_CMPTR; j++) begin
      avail[OC_CMPTR_BASE + 6'(j)] = comparator_output[j];
    end
    avail[OC_S3_TX] = serial3_transmit;
    avail[OC_S3_RTS] = serial3_request_to_send;
    avail[OC_NULL] = 1'b0;
  end

  // code 0 is ground, 1 the first comparator, the rest pin numbers
  function automatic logic pick_in(input logic [ISEL_W-1:0] sel,
                                   input logic [NUM_IN_PINS-1:0] pins,
                                   input logic comparator1_result);
    logic v;
    v = pins[sel];
    if (sel == ISEL_VSS) begin
      v = 1'b0;
    end else if (sel == ISEL_COMPARATOR1_RESULT) begin
      v = comparator1_result;
    end
    return v;
  endfunction

  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    // register writes; upper unused bits are simply never stored
    if (reg_wr) begin
      case (reg_addr)
        ADDR_IN_TIMER: begin
          next_st.sel_t2 = reg_wdata[FLD_LO +: ISEL_W];
          next_st.sel_t3 = reg_wdata[FLD_HI +: ISEL_W];
        end
        ADDR_IN_FSYNC: begin
          next_st.sel_fs = reg_wdata[FLD_LO +: ISEL_W];
        end
        ADDR_IN_CAPT: begin
          next_st.sel_ic11 = reg_wdata[FLD_LO +: ISEL_W];
          next_st.sel_ic12 = reg_wdata[FLD_HI +: ISEL_W];
        end
        default: begin
          for (int k = 0; k < NUM_OREGS; k++) begin
            if (reg_addr == ADDR_OUT_BASE + 8'(k)) begin
              next_st.osel[2*k] = reg_wdata[FLD_LO +: OSEL_W];
              next_st.osel[2*k+1] = reg_wdata[FLD_HI +: OSEL_W];
            end
          end
        end
      endcase
    end
    // read data stands for one cycle only; unmapped reads give zero
    if (reg_rd) begin
      case (reg_addr)
        ADDR_IN_TIMER: begin
          next_st.rdata[FLD_LO +: ISEL_W] = st.sel_t2;
          next_st.rdata[FLD_HI +: ISEL_W] = st.sel_t3;
        end
        ADDR_IN_FSYNC: begin
          next_st.rdata[FLD_LO +: ISEL_W] = st.sel_fs;
        end
        ADDR_IN_CAPT: begin
          next_st.rdata[FLD_LO +: ISEL_W] = st.sel_ic11;
          next_st.rdata[FLD_HI +: ISEL_W] = st.sel_ic12;
        end
        default: begin
          for (int k = 0; k < NUM_OREGS; k++) begin
            if (reg_addr == ADDR_OUT_BASE + 8'(k)) begin
              next_st.rdata[FLD_LO +: OSEL_W] = st.osel[2*k];
              next_st.rdata[FLD_HI +: OSEL_W] = st.osel[2*k+1];
            end
          end
        end
      endcase
    end
    // output routing, one cycle of latency keeps every output a flop
    for (int i = 0; i < NUM_PINS; i++) begin
      next_st.remapped[i] = (st.osel[i] != OC_NULL);
      next_st.pin[i] = (st.osel[i] == OC_NULL) ? port_data[i]
                       : avail[st.osel[i]];
    end
    // input routing, same one-cycle latency as the outputs
    next_st.t2 = pick_in(st.sel_t2, remappable_pin_in,
                         comparator_output[0]);
    next_st.t3 = pick_in(st.sel_t3, remappable_pin_in,
                         comparator_output[0]);
    next_st.fs = pick_in(st.sel_fs, remappable_pin_in,
                         comparator_output[0]);
    next_st.ic11 = pick_in(st.sel_ic11, remappable_pin_in,
                           comparator_output[0]);
    next_st.ic12 = pick_in(st.sel_ic12, remappable_pin_in,
                           comparator_output[0]);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.osel <= {NUM_PINS{OSEL_RESET}};
      st.sel_t2 <= ISEL_RESET;
      st.sel_t3 <= ISEL_RESET;
      st.sel_fs <= ISEL_RESET;
      st.sel_ic11 <= ISEL_RESET;
      st.sel_ic12 <= ISEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign remappable_pin = st.pin;
  assign pin_remapped = st.remapped;
  assign timer2_clock_in = st.t2;
  assign timer3_clock_in = st.t3;
  assign frame_sync_in = st.fs;
  assign capture11_in = st.ic11;
  assign capture12_in = st.ic12;

endmodule

/* File: sim/ppsm_periph.sv */
// peripheral side model: level sources that change most cycles
`timescale 1ns/100ps
module ppsm_periph (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic [28:0] src,
  output logic [127:0] pins
);
  // shifted pseudo-random streams, so a neighbouring select disagrees soon
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src <= 29'h0;
      pins <= 128'h0;
    end else begin
      src <= {src[27:0], ~(src[28] ^ src[25])};
      pins <= {pins[126:0], ~(pins[127] ^ src[3])};
    end
  end
endmodule

/* File: sim/ppsm_mux_assertions.sv */
// concurrent checks on the pin select matrix ports
`timescale 1ns/100ps
module ppsm_chk
  import ppsm_pkg::*;
#(parameter int NUM_PINS = 8) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic serial1_transmit,
  input wire logic [NUM_CMPCH-1:0] compare_channel_output,
  input wire logic [NUM_PINS-1:0] port_data,
  input wire logic [NUM_PINS-1:0] remappable_pin,
  input wire logic [NUM_PINS-1:0] pin_remapped,
  input wire logic [NUM_IN_PINS-1:0] remappable_pin_in,
  input wire logic frame_sync_in
);
  // shadows of pin 0 and frame sync fields; the ports do not show them
  logic [5:0] f0;
  logic [6:0] fs;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      f0 <= 6'h00;
      fs <= 7'h00;
    end else if (reg_wr && reg_addr == ADDR_OUT_BASE) begin
      f0 <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == ADDR_IN_FSYNC) begin
      fs <= reg_wdata[6:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rd_rsv_a: assert property ($past(reg_rd) |->
    !reg_rdata[15] && !reg_rdata[7]) else $error("reserved bit set");
  out_null_a: assert property ($past(rst_n) && !pin_remapped[0] |->
    remappable_pin[0] == $past(port_data[0])) else $error("port lost");
  out_flag_a: assert property ($past(rst_n) |->
    pin_remapped[0] == ($past(f0) != 6'h00)) else $error("flag wrong");
  out_s1_a: assert property ($past(f0) == OC_S1_TX |->
    remappable_pin[0] == $past(serial1_transmit)) else $error("tx wrong");
  out_cmp_a: assert property ($past(f0) inside {[16:23]} |->
    remappable_pin[0] == $past(compare_channel_output[f0[2:0]]))
    else $error("compare wrong");
  out_none_a: assert property ($past(f0) inside {8, 9, [29:63]} |->
    !remappable_pin[0]) else $error("unassigned drives");
  in_gnd_a: assert property (fs == ISEL_VSS |=>
    !frame_sync_in) else $error("ground wrong");
  in_pin_a: assert property (fs > 7'h01 |=>
    frame_sync_in == $past(remappable_pin_in[fs])) else $error("pin wrong");
endmodule
bind ppsm_mux ppsm_chk #(.NUM_PINS(NUM_PINS)) u_chk (.clk_sys, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial1_transmit,
  .compare_channel_output, .port_data, .remappable_pin, .pin_remapped,
  .remappable_pin_in, .frame_sync_in);

/* File: sim/tb.sv */
// self-checking bench for the pin select matrix
`timescale 1ns/100ps
module tb
  import ppsm_pkg::*;
;
  logic clk_sys, rst_n, reg_wr, reg_rd, ti2, ti3, fsi, ca11, ca12;
  logic [7:0] reg_addr, port_data, pd_q, pin_o, flg;
  logic [15:0] reg_wdata, reg_rdata;
  logic [28:0] src, src_q;
  logic [127:0] pins, pins_q;
  logic [5:0] ins;
  logic [6:0] sel [6] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h40, 7'h7F};
  int mismatches, check_count;
  assign ins = {ca12, ca11, 1'b0, fsi, ti3, ti2};
  ppsm_periph u_per (.clk_sys, .rst_n, .src, .pins);
  ppsm_mux #(.NUM_PINS(8)) u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .serial1_transmit(src[1]),
    .serial1_request_to_send(src[2]), .serial2_transmit(src[3]),
    .serial2_request_to_send(src[4]), .serial3_transmit(src[27]),
    .serial3_request_to_send(src[28]), .spi1_data_out(src[5]),
    .spi1_clock_out(src[6]), .spi1_slave_select(src[7]),
    .spi2_slave_select(src[10]), .codec_serial_data_out(src[11]),
    .codec_serial_clock(src[12]), .codec_frame_sync(src[13]),
    .can1_transmit(src[14]), .can2_transmit(src[15]),
    .compare_channel_output(src[23:16]), .comparator_output(src[26:24]),
    .port_data, .remappable_pin(pin_o), .pin_remapped(flg),
    .remappable_pin_in(pins), .timer2_clock_in(ti2), .timer3_clock_in(ti3),
    .frame_sync_in(fsi), .capture11_in(ca11), .capture12_in(ca12));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // the design samples inputs one edge before its outputs show them
  always @(posedge clk_sys) begin
    port_data <= port_data + 8'h35;
    {pd_q, src_q, pins_q} <= {port_data, src, pins};
  end
  function automatic logic eo(logic [5:0] c, logic pd);
    if (c == 6'h00) return pd;
    if (c > 6'h1C || c == 6'h08 || c == 6'h09) return 1'b0;
    return src_q[c];
  endfunction
  function automatic logic ei(logic [6:0] s);
    if (s < 7'h02) return s[0] & src_q[24];
    return pins_q[s];
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
    #1 if (!w) chk("rdata", d, reg_rdata);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, (i == 3) ? ADDR_OUT_BASE : 8'(i), 16'h0000);
    end
    bus(1'b1, 8'h14, 16'hFFFF);
    bus(1'b0, 8'h14, 16'h0000);
  endtask
  task automatic t_out(logic [5:0] c);
    logic e0, e1;
    bus(1'b1, ADDR_OUT_BASE, {2'b11, ~c, 2'b11, c});
    bus(1'b0, ADDR_OUT_BASE, {2'b00, ~c, 2'b00, c});
    repeat (3) begin
      @(negedge clk_sys);
      // pins 2 and up keep field zero, so they must show the port value
      e0 = eo(c, pd_q[0]);
      e1 = eo(~c, pd_q[1]);
      chk("pin", {8'h00, pd_q[7:2], e1, e0}, {8'h00, pin_o});
      chk("flag", {14'h0, ~c != 6'h00, c != 6'h00}, {8'h00, flg});
    end
  endtask
  task automatic t_in(int a, logic [6:0] l, logic [6:0] h);
    logic [6:0] eh;
    eh = (a == 1) ? 7'h00 : h;
    bus(1'b1, 8'(a), {1'b1, h, 1'b1, l});
    bus(1'b0, 8'(a), {1'b0, eh, 1'b0, l});
    repeat (3) begin
      @(negedge clk_sys);
      chk("input", {14'h0, ei(eh), ei(l)},
        {14'h0, ins[a*2 +: 2]});
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, port_data} = 35'h0;
    {mismatches, check_count} = 64'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    for (int i = 0; i < 64; i++) t_out(6'(i));
    for (int i = 0; i < 18; i++) t_in(i / 6, sel[i % 6], sel[5 - i % 6]);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    stop_test();
  end
endmodule
